// [design/tss_supervisor.sv]
`timescale 1ns/10ps
`default_nettype none
module tss_supervisor
  import tss_pkg::*;
#(
  parameter int unsigned CLK_KHZ = CLK_KHZ_DEF,
  parameter bit PUSH_PULL_VARIANT = 1'b0,
  parameter int unsigned HOLD0_CYC = HOLD_T0_MS * CLK_KHZ,
  parameter int unsigned HOLD1_CYC = HOLD_T1_MS * CLK_KHZ,
  parameter int unsigned HOLD2_CYC = HOLD_T2_MS * CLK_KHZ,
  parameter int unsigned HOLD3_CYC = HOLD_T3_MS * CLK_KHZ,
  parameter int unsigned WD0_CYC = WD_T0_MS * CLK_KHZ,
  parameter int unsigned WD1_CYC = WD_T1_MS * CLK_KHZ,
  parameter int unsigned WD2_CYC = WD_T2_MS * CLK_KHZ,
  parameter int unsigned MR_DEB_CYC = MR_DEBOUNCE_US * CLK_KHZ / US_PER_MS
) (
  // clocks and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bus_clk,
  // two-wire bus pins
  input wire logic sda,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic scl,
  // supply comparator results, high means condition true
  input wire logic vcc_below_first,
  input wire logic second_monitor_input_low,
  input wire logic second_monitor_input_clear,
  input wire logic third_monitor_input_low,
  input wire logic third_monitor_input_clear,
  // push-button and write lock pins
  input wire logic manual_reset_n,
  input wire logic write_lock,
  // stored settings update, same clock domain
  input wire logic setting_write,
  input wire logic new_reset_hold_select_hi,
  input wire logic new_reset_hold_select_lo,
  input wire logic new_watchdog_period_select_hi,
  input wire logic new_watchdog_period_select_lo,
  // stored settings readback
  output logic reset_hold_select_hi,
  output logic reset_hold_select_lo,
  output logic watchdog_period_select_hi,
  output logic watchdog_period_select_lo,
  // system reset, both variants
  output logic system_reset_n_out,
  output logic system_reset_n_oe_n,
  output logic system_reset,
  // supply flags
  output logic early_supply_low_n,
  output logic second_supply_fail_n_out,
  output logic second_supply_fail_n_oe_n,
  output logic third_supply_fail_n_out,
  output logic third_supply_fail_n_oe_n,
  // watchdog
  output logic watchdog_out_n_out,
  output logic watchdog_out_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: zero counts would never expire or release
  if (CLK_KHZ == 0) begin : g_bad_clk
    $error("clock rate must be nonzero");
  end
  if (HOLD0_CYC == 0 || HOLD1_CYC == 0 || HOLD2_CYC == 0 ||
      HOLD3_CYC == 0) begin : g_bad_hold
    $error("hold counts must be at least one cycle");
  end
  if (WD0_CYC == 0 || WD1_CYC == 0 || WD2_CYC == 0) begin : g_bad_wd
    $error("watchdog counts must be at least one cycle");
  end
  if (MR_DEB_CYC == 0) begin : g_bad_deb
    $error("debounce count must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: one toggle per falling bus clock edge
  logic link_tgl_r;

  // bus clock may stop between frames; the toggle simply holds
  always_ff @(negedge bus_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_tgl_r <= 1'b0;
    end else begin
      link_tgl_r <= ~link_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  wire logic [SYNC_W-1:0] raw_in;
  wire logic [SYNC_W-1:0] sync_q;

  assign raw_in[SI_SDA] = sda;
  assign raw_in[SI_SCL] = scl;
  assign raw_in[SI_MR_N] = manual_reset_n;
  assign raw_in[SI_VCC_LOW] = vcc_below_first;
  assign raw_in[SI_V2_LOW] = second_monitor_input_low;
  assign raw_in[SI_V2_CLR] = second_monitor_input_clear;
  assign raw_in[SI_V3_LOW] = third_monitor_input_low;
  assign raw_in[SI_V3_CLR] = third_monitor_input_clear;
  assign raw_in[SI_WLOCK] = write_lock;
  assign raw_in[SI_LINK] = link_tgl_r;

  // sda, scl, button, supply and lock pins and the link toggle settle here before use
  tss_pin_sync #(
    .W(SYNC_W),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(raw_in),
    .q(sync_q)
  );

  wire logic sda_q = sync_q[SI_SDA];
  wire logic scl_q = sync_q[SI_SCL];
  wire logic mr_low_q = ~sync_q[SI_MR_N];
  wire logic vcc_low_q = sync_q[SI_VCC_LOW];
  wire logic v2_low_q = sync_q[SI_V2_LOW];
  wire logic v2_clr_q = sync_q[SI_V2_CLR];
  wire logic v3_low_q = sync_q[SI_V3_LOW];
  wire logic v3_clr_q = sync_q[SI_V3_CLR];
  wire logic wlock_q = sync_q[SI_WLOCK];
  wire logic link_q = sync_q[SI_LINK];

  ////////////////////////////////////////////////////////////////////////////
  // stored settings
  logic [1:0] hold_sel_r;
  logic [1:0] wd_sel_r;
  wire logic set_take;

  // lock pin blocks every setting update
  assign set_take = setting_write & ~wlock_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_sel_r <= HOLD_SEL_RST;
      wd_sel_r <= WD_SEL_RST;
    end else if (set_take) begin
      hold_sel_r <= {new_reset_hold_select_hi, new_reset_hold_select_lo};
      wd_sel_r <= {new_watchdog_period_select_hi,
                   new_watchdog_period_select_lo};
    end
  end

  assign reset_hold_select_hi = hold_sel_r[1];
  assign reset_hold_select_lo = hold_sel_r[0];
  assign watchdog_period_select_hi = wd_sel_r[1];
  assign watchdog_period_select_lo = wd_sel_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // terminal counts
  wire logic [31:0] hold_target;
  wire logic [31:0] wd_target;
  wire logic wd_off;

  assign hold_target = (hold_sel_r == 2'h0) ? 32'(HOLD0_CYC) :
                       (hold_sel_r == 2'h1) ? 32'(HOLD1_CYC) :
                       (hold_sel_r == 2'h2) ? 32'(HOLD2_CYC) :
                       32'(HOLD3_CYC);
  assign wd_target = (wd_sel_r == 2'h0) ? 32'(WD0_CYC) :
                     (wd_sel_r == 2'h1) ? 32'(WD1_CYC) :
                     32'(WD2_CYC);
  assign wd_off = (wd_sel_r == WD_SEL_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // push-button debounce
  logic mr_active_r;
  logic [31:0] deb_cnt_r;
  logic [31:0] deb_cnt_nxt;
  wire logic deb_diff;
  wire logic deb_done;

  // a bounce shorter than the window restarts the count
  assign deb_diff = mr_low_q ^ mr_active_r;
  assign deb_done = deb_diff & (deb_cnt_r >= 32'(MR_DEB_CYC) - CNT_ONE);
  assign deb_cnt_nxt = (!deb_diff || deb_done) ? CNT_ZERO :
                       deb_cnt_r + CNT_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mr_active_r <= 1'b0;
      deb_cnt_r <= CNT_ZERO;
    end else begin
      deb_cnt_r <= deb_cnt_nxt;
      if (deb_done) begin
        mr_active_r <= mr_low_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system reset sequencer
  tss_rst_state_t rst_state_r;
  tss_rst_state_t rst_state_nxt;
  logic [31:0] hold_cnt_r;
  logic [31:0] hold_cnt_nxt;
  wire logic rst_fault;
  wire logic hold_done;

  assign rst_fault = vcc_low_q | mr_active_r;
  assign hold_done = (hold_cnt_r >= hold_target - CNT_ONE);

  // any fault during the hold restarts it from zero
  always_comb begin
    rst_state_nxt = rst_state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (rst_state_r)
      RST_HOLD: begin
        if (rst_fault) begin
          hold_cnt_nxt = CNT_ZERO;
        end else if (hold_done) begin
          hold_cnt_nxt = CNT_ZERO;
          rst_state_nxt = RST_RUN;
        end else begin
          hold_cnt_nxt = hold_cnt_r + CNT_ONE;
        end
      end
      RST_RUN: begin
        if (rst_fault) begin
          hold_cnt_nxt = CNT_ZERO;
          rst_state_nxt = RST_HOLD;
        end
      end
      default: begin
        hold_cnt_nxt = CNT_ZERO;
        rst_state_nxt = RST_HOLD;
      end
    endcase
  end

  // power-up lands in the hold state, reset already asserted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_state_r <= RST_HOLD;
      hold_cnt_r <= CNT_ZERO;
    end else begin
      rst_state_r <= rst_state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  wire logic rst_asserted = (rst_state_r == RST_HOLD);

  // same timing in both variants; the unused one stays inactive
  assign system_reset_n_out = 1'b0;
  assign system_reset_n_oe_n = PUSH_PULL_VARIANT ? 1'b1 :
                               ~rst_asserted;
  assign system_reset = PUSH_PULL_VARIANT ? rst_asserted : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // supply flags, no hold delay
  logic v2_fail_r;
  logic v3_fail_r;

  // low sets, hysteresis comparator clears; set wins when both seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      v2_fail_r <= 1'b0;
      v3_fail_r <= 1'b0;
    end else begin
      if (v2_low_q) begin
        v2_fail_r <= 1'b1;
      end else if (v2_clr_q) begin
        v2_fail_r <= 1'b0;
      end
      if (v3_low_q) begin
        v3_fail_r <= 1'b1;
      end else if (v3_clr_q) begin
        v3_fail_r <= 1'b0;
      end
    end
  end

  assign second_supply_fail_n_out = 1'b0;
  assign second_supply_fail_n_oe_n = ~v2_fail_r;
  assign third_supply_fail_n_out = 1'b0;
  assign third_supply_fail_n_oe_n = ~v3_fail_r;
  // leads the system reset: no sequencer in this path
  assign early_supply_low_n = ~vcc_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus condition detection, never gated by addressing
  logic sda_d_r;
  logic link_d_r;
  wire logic start_seen;
  wire logic stop_seen;
  wire logic clk_fall_seen;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_d_r <= 1'b1;
      link_d_r <= 1'b0;
    end else begin
      sda_d_r <= sda_q;
      link_d_r <= link_q;
    end
  end

  assign start_seen = sda_d_r & ~sda_q & scl_q;
  assign stop_seen = ~sda_d_r & sda_q & scl_q;
  assign clk_fall_seen = link_d_r ^ link_q;

  ////////////////////////////////////////////////////////////////////////////
  // restart sequence: start, a bus clock fall, then stop
  tss_wd_state_t wd_state_r;
  tss_wd_state_t wd_state_nxt;
  logic wd_restart;

  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_restart = 1'b0;
    case (wd_state_r)
      WD_IDLE: begin
        if (start_seen) begin
          wd_state_nxt = WD_START;
        end
      end
      WD_START: begin
        if (stop_seen) begin
          wd_state_nxt = WD_IDLE;
        end else if (clk_fall_seen) begin
          wd_state_nxt = WD_CLOCKED;
        end
      end
      WD_CLOCKED: begin
        if (stop_seen) begin
          wd_restart = 1'b1;
          wd_state_nxt = WD_IDLE;
        end else if (start_seen) begin
          wd_state_nxt = WD_START;
        end
      end
      default: begin
        wd_state_nxt = WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_state_r <= WD_IDLE;
    end else begin
      wd_state_r <= wd_state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog timer
  logic [31:0] wd_cnt_r;
  logic [31:0] wd_cnt_nxt;
  logic wd_expired_r;
  wire logic wd_term;

  // terminal reached while counting; expiry beats a same-cycle restart
  assign wd_term = ~wd_off & ~wd_expired_r &
                   (wd_cnt_r >= wd_target - CNT_ONE);
  assign wd_cnt_nxt = (wd_off || wd_restart || wd_term) ? CNT_ZERO :
                      wd_expired_r ? wd_cnt_r :
                      wd_cnt_r + CNT_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_r <= CNT_ZERO;
      wd_expired_r <= 1'b0;
    end else begin
      wd_cnt_r <= wd_cnt_nxt;
      if (wd_off) begin
        wd_expired_r <= 1'b0;
      end else if (wd_term) begin
        wd_expired_r <= 1'b1;
      end else if (wd_restart) begin
        wd_expired_r <= 1'b0;
      end
    end
  end

  // open drain: pull low only while expired
  assign watchdog_out_n_out = 1'b0;
  assign watchdog_out_n_oe_n = ~wd_expired_r;

  // command decoding is elsewhere; the data line is only watched here
  assign sda_out = 1'b0;
  assign sda_oe_n = 1'b1;

endmodule
`default_nettype wire

// [design/tss_pkg.sv]
`default_nettype none
package tss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock rate and timing figures
  localparam int unsigned CLK_KHZ_DEF = 200000;
  localparam int unsigned HOLD_T0_MS = 50;
  localparam int unsigned HOLD_T1_MS = 200;
  localparam int unsigned HOLD_T2_MS = 400;
  localparam int unsigned HOLD_T3_MS = 800;
  localparam int unsigned WD_T0_MS = 1400;
  localparam int unsigned WD_T1_MS = 200;
  localparam int unsigned WD_T2_MS = 25;
  localparam int unsigned MR_DEBOUNCE_US = 1000;
  localparam int unsigned US_PER_MS = 1000;

  ////////////////////////////////////////////////////////////////////////////
  // setting codes and reset values
  localparam logic [1:0] WD_SEL_OFF = 2'h3;
  localparam logic [1:0] HOLD_SEL_RST = 2'h0;
  localparam logic [1:0] WD_SEL_RST = 2'h0;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // positions in the synchroniser vector
  localparam int unsigned SI_SDA = 0;
  localparam int unsigned SI_SCL = 1;
  localparam int unsigned SI_MR_N = 2;
  localparam int unsigned SI_VCC_LOW = 3;
  localparam int unsigned SI_V2_LOW = 4;
  localparam int unsigned SI_V2_CLR = 5;
  localparam int unsigned SI_V3_LOW = 6;
  localparam int unsigned SI_V3_CLR = 7;
  localparam int unsigned SI_WLOCK = 8;
  localparam int unsigned SI_LINK = 9;
  localparam int unsigned SYNC_W = 10;
  // idle bus high, button open, supply taken as low until seen good
  localparam logic [SYNC_W-1:0] SYNC_INIT = 10'h00f;

  ////////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic {
    RST_HOLD = 1'b0,
    RST_RUN = 1'b1
  } tss_rst_state_t;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_START = 2'b01,
    WD_CLOCKED = 2'b10
  } tss_wd_state_t;

endpackage
`default_nettype wire

// [design/tss_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module tss_pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // raw and settled levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  wire logic [W-1:0] agree;
  wire logic [W-1:0] q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // settled value moves only where stages two and three agree
  assign agree = ~(s2_r ^ s3_r);
  assign q_nxt = (agree & s2_r) | (~agree & q_r);
  assign q = q_r;

  // first stage feeds only the second, to contain metastability
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// [verification/tss_supervisor_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tss_supervisor_asserts #(
  parameter int unsigned HOLD0_CYC = 200,
  parameter int unsigned MR_DEB_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // watched inputs
  input wire logic vcc_below_first,
  input wire logic second_monitor_input_low,
  input wire logic third_monitor_input_low,
  input wire logic third_monitor_input_clear,
  input wire logic manual_reset_n,
  input wire logic write_lock,
  input wire logic setting_write,
  input wire logic new_reset_hold_select_hi,
  input wire logic new_reset_hold_select_lo,
  // watched outputs
  input wire logic reset_hold_select_hi,
  input wire logic reset_hold_select_lo,
  input wire logic watchdog_period_select_hi,
  input wire logic watchdog_period_select_lo,
  input wire logic system_reset_n_oe_n,
  input wire logic early_supply_low_n,
  input wire logic second_supply_fail_n_oe_n,
  input wire logic third_supply_fail_n_oe_n,
  input wire logic watchdog_out_n_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // raw fault-free run and button-low run; raw leads settled, so a bound
  logic [31:0] ok_cnt_r;
  logic [31:0] mr_cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_cnt_r <= 32'h0;
      mr_cnt_r <= 32'h0;
    end else begin
      ok_cnt_r <= (vcc_below_first || !manual_reset_n) ? 32'h0 : ok_cnt_r + 1;
      mr_cnt_r <= manual_reset_n ? 32'h0 : mr_cnt_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervisor relations
  AST_RST_HOLD: assert property ($rose(system_reset_n_oe_n) |->
    ok_cnt_r >= HOLD0_CYC) else $error("reset released too early");
  AST_MR_RST: assert property (mr_cnt_r > MR_DEB_CYC + 8 |->
    !system_reset_n_oe_n) else $error("button low without reset");
  AST_VCC_RST: assert property (vcc_below_first [*8] |->
    !system_reset_n_oe_n) else $error("low supply without reset");
  AST_EARLY_LO: assert property (vcc_below_first [*6] |->
    !early_supply_low_n) else $error("early low missing");
  AST_EARLY_HI: assert property (!vcc_below_first [*6] |->
    early_supply_low_n) else $error("early low stuck");
  AST_V2_SET: assert property (second_monitor_input_low [*6] |->
    !second_supply_fail_n_oe_n) else $error("second fail missing");
  AST_V3_SET: assert property (third_monitor_input_low [*6] |->
    !third_supply_fail_n_oe_n) else $error("third fail missing");
  AST_V3_CLR: assert property ((!third_monitor_input_low &&
    third_monitor_input_clear) [*6] |-> third_supply_fail_n_oe_n)
    else $error("third fail not cleared");
  AST_WD_OFF: assert property ((watchdog_period_select_hi &&
    watchdog_period_select_lo) [*3] |-> watchdog_out_n_oe_n)
    else $error("watchdog active while off");
  AST_LOCK: assert property (write_lock [*6] ##0 setting_write |=>
    $stable({reset_hold_select_hi, reset_hold_select_lo}))
    else $error("locked write taken");
  AST_WRITE: assert property (!write_lock [*6] ##0 setting_write |=>
    {reset_hold_select_hi, reset_hold_select_lo} ==
    $past({new_reset_hold_select_hi, new_reset_hold_select_lo}))
    else $error("write not taken");

  // main scenarios
  cover property ($rose(system_reset_n_oe_n));
  cover property ($fell(watchdog_out_n_oe_n));
  cover property ($fell(third_supply_fail_n_oe_n));
endmodule

bind tss_supervisor tss_supervisor_asserts #(.HOLD0_CYC(HOLD0_CYC),
  .MR_DEB_CYC(MR_DEB_CYC)) i_chk (.clk(clk), .arst_n(arst_n),
  .vcc_below_first(vcc_below_first),
  .second_monitor_input_low(second_monitor_input_low),
  .third_monitor_input_low(third_monitor_input_low),
  .third_monitor_input_clear(third_monitor_input_clear),
  .manual_reset_n(manual_reset_n), .write_lock(write_lock),
  .setting_write(setting_write),
  .new_reset_hold_select_hi(new_reset_hold_select_hi),
  .new_reset_hold_select_lo(new_reset_hold_select_lo),
  .reset_hold_select_hi(reset_hold_select_hi),
  .reset_hold_select_lo(reset_hold_select_lo),
  .watchdog_period_select_hi(watchdog_period_select_hi),
  .watchdog_period_select_lo(watchdog_period_select_lo),
  .system_reset_n_oe_n(system_reset_n_oe_n),
  .early_supply_low_n(early_supply_low_n),
  .second_supply_fail_n_oe_n(second_supply_fail_n_oe_n),
  .third_supply_fail_n_oe_n(third_supply_fail_n_oe_n),
  .watchdog_out_n_oe_n(watchdog_out_n_oe_n));
`default_nettype wire

// [verification/tss_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tss_host_model (
  // request from bench
  input wire logic go,
  output logic busy,
  // bus wires, pulled up when idle
  output logic scl,
  output logic sda
);
  initial begin
    busy = 1'b0;
    scl = 1'b1;
    sda = 1'b1;
  end

  // start, three 12 ns clocks, stop; clock stands high between frames
  always @(posedge go) begin
    busy = 1'b1;
    #7 sda = 1'b0;
    #30;
    repeat (3) begin
      #6 scl = 1'b0;
      #6 scl = 1'b1;
    end
    #30 sda = 1'b1;
    #30 busy = 1'b0;
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tss_pkg::*;
  // shortened hold and watchdog counts, element 0 is code 00
  localparam logic [3:0][15:0] HC = {16'h0320, 16'h0258, 16'h0190, 16'h00c8};
  localparam logic [2:0][15:0] WC = {16'h03e8, 16'h07d0, 16'h0bb8};
  typedef struct packed {int sel; logic [1:0] exp;} tss_note_t;
  logic clk, arst_n, go, busy, scl, sda, vcc, v2l, v2c, v3l, v3c;
  logic mr_n, wl, sw, e2, e3;
  logic [1:0] nh, nw;
  wire logic [1:0] hs, ws;
  logic rst_oe_n, early_n, f2, f3, wd;
  // pins that must sit at fixed levels in the open-drain variant
  wire logic d_out, d_oe_n, rst_hi, rst_lo, f2_lo, f3_lo, wd_lo;
  logic [1:0] obs [9];
  string nm [9] = '{"reset", "early", "fail2", "fail3", "wdog", "hsel",
    "wsel", "fixhi", "fixlo"};
  tss_note_t notes [$];
  tss_note_t n;
  int miscompares, n_checks, seed, i, r;

  tss_host_model i_host (.go(go), .busy(busy), .scl(scl), .sda(sda));
  tss_supervisor #(.HOLD0_CYC(HC[0]), .HOLD1_CYC(HC[1]), .HOLD2_CYC(HC[2]),
    .HOLD3_CYC(HC[3]), .WD0_CYC(WC[0]), .WD1_CYC(WC[1]), .WD2_CYC(WC[2]),
    .MR_DEB_CYC(20)) i_dut (.clk(clk), .arst_n(arst_n), .bus_clk(scl),
    .sda(sda), .sda_out(d_out), .sda_oe_n(d_oe_n), .scl(scl),
    .vcc_below_first(vcc),
    .second_monitor_input_low(v2l), .second_monitor_input_clear(v2c),
    .third_monitor_input_low(v3l), .third_monitor_input_clear(v3c),
    .manual_reset_n(mr_n), .write_lock(wl), .setting_write(sw),
    .new_reset_hold_select_hi(nh[1]), .new_reset_hold_select_lo(nh[0]),
    .new_watchdog_period_select_hi(nw[1]),
    .new_watchdog_period_select_lo(nw[0]),
    .reset_hold_select_hi(hs[1]), .reset_hold_select_lo(hs[0]),
    .watchdog_period_select_hi(ws[1]), .watchdog_period_select_lo(ws[0]),
    .system_reset_n_out(rst_lo), .system_reset_n_oe_n(rst_oe_n),
    .system_reset(rst_hi), .early_supply_low_n(early_n),
    .second_supply_fail_n_out(f2_lo), .second_supply_fail_n_oe_n(f2),
    .third_supply_fail_n_out(f3_lo), .third_supply_fail_n_oe_n(f3),
    .watchdog_out_n_out(wd_lo), .watchdog_out_n_oe_n(wd));

  ////////////////////////////////////////////////////////////////////////////
  // clock, observed values and the comparing process
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always_comb begin
    obs[0] = {1'b0, rst_oe_n};
    obs[1] = {1'b0, early_n};
    obs[2] = {1'b0, f2};
    obs[3] = {1'b0, f3};
    obs[4] = {1'b0, wd};
    obs[5] = hs;
    obs[6] = ws;
    // data line never driven, push-pull reset unused, open drains pull low
    obs[7] = {d_oe_n, d_out | rst_hi};
    obs[8] = {rst_lo | f2_lo, f3_lo | wd_lo};
  end
  // outputs move only on edges, so the next edge still sees the noted value
  always @(posedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      n_checks++;
      if (obs[n.sel] !== n.exp) begin
        miscompares++;
        $display("[ERR] %s expected %h seen %h", nm[n.sel], n.exp, obs[n.sel]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver tasks
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input int s, input logic [1:0] e);
    notes.push_back('{s, e});
  endtask
  task set_codes(input logic [1:0] h, input logic [1:0] w);
    sw = 1'b1;
    nh = h;
    nw = w;
    tick(1);
    sw = 1'b0;
    tick(1);
  endtask
  task restart();
    int k;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (k = 0; k < 100 && busy !== 1'b0; k++) tick(1);
    // a host frame that never ends is a failure, not a silent skip
    if (busy !== 1'b0) begin
      miscompares++;
      $display("[ERR] busy expected 0 seen %b", busy);
    end
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang is cut short well past the planned run length
  initial begin
    #500000;
    miscompares++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {go, v2l, v2c, v3l, v3c, wl, sw, e2, e3} = '0;
    {nh, nw} = 4'h0;
    {vcc, mr_n} = 2'h3;
    miscompares = 0;
    n_checks = 0;
    seed = 51;
    arst_n = 1'b0;
    tick(1);
    chk(0, 2'h0);
    tick(1);
    arst_n = 1'b1;
    chk(0, 2'h0);
    chk(7, 2'h2);
    chk(8, 2'h0);
    tick(10);
    vcc = 1'b0;
    tick(HC[0] - 20);
    chk(0, 2'h0);
    tick(40);
    chk(0, 2'h1);
    for (i = 0; i < 4; i++) begin
      set_codes(i[1:0], WD_SEL_OFF);
      chk(5, i[1:0]);
      vcc = 1'b1;
      tick(10);
      chk(0, 2'h0);
      chk(1, 2'h0);
      vcc = 1'b0;
      tick(10);
      chk(1, 2'h1);
      tick(HC[i] / 2);
      vcc = 1'b1;
      tick(6);
      vcc = 1'b0;
      tick(HC[i] - 20);
      chk(0, 2'h0);
      tick(40);
      chk(0, 2'h1);
    end
    set_codes(2'h0, WD_SEL_OFF);
    mr_n = 1'b0;
    tick(60);
    chk(0, 2'h0);
    chk(1, 2'h1);
    mr_n = 1'b1;
    tick(HC[0]);
    chk(0, 2'h0);
    tick(60);
    chk(0, 2'h1);
    wl = 1'b1;
    tick(8);
    set_codes(2'h3, 2'h1);
    chk(5, 2'h0);
    chk(6, 2'h3);
    wl = 1'b0;
    tick(8);
    for (i = 0; i < 3; i++) begin
      set_codes(2'h0, i[1:0]);
      chk(6, i[1:0]);
      restart();
      tick(WC[i] - 60);
      chk(4, 2'h1);
      tick(120);
      chk(4, 2'h0);
      restart();
      tick(20);
      chk(4, 2'h1);
    end
    set_codes(2'h0, WD_SEL_OFF);
    restart();
    tick(3500);
    chk(4, 2'h1);
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      {vcc, v3c, v3l, v2c, v2l} = r[4:0];
      if (r[0]) e2 = 1'b1;
      else if (r[1]) e2 = 1'b0;
      if (r[2]) e3 = 1'b1;
      else if (r[3]) e3 = 1'b0;
      tick(8);
      chk(2, {1'b0, !e2});
      chk(3, {1'b0, !e3});
      chk(1, {1'b0, !r[4]});
    end
    chk(7, 2'h2);
    chk(8, 2'h0);
    tick(4);
    finish_test();
  end
endmodule
`default_nettype wire
